// *** lfcb_byte_reg.sv ***
// Purpose: one byte-wide coefficient register with a fixed reset value
// Assumes: synchronous active-high reset
// Notes:   write enable is a one-cycle strobe from the bus slave
`timescale 1ns/100ps
module lfcb_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end

endmodule : lfcb_byte_reg

// *** lfcb_pkg.sv ***
// Purpose: constants for the left filter coefficient bank
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   printed offsets are register indices, byte address is four times the index
package lfcb_pkg;

  localparam int          NUM_REGS   = 10;
  localparam int          NUM_COEFS  = 5;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          BYTE_W     = 8;
  localparam int          COEF_W     = 16;

  // register indices
  localparam logic [7:0]  IDX_FB2_HIGH  = 8'h0f;
  localparam logic [7:0]  IDX_FB2_LOW   = 8'h10;
  localparam logic [7:0]  IDX_FB4_HIGH  = 8'h11;
  localparam logic [7:0]  IDX_FB4_LOW   = 8'h12;
  localparam logic [7:0]  IDX_FB5_HIGH  = 8'h13;
  localparam logic [7:0]  IDX_FB5_LOW   = 8'h14;
  localparam logic [7:0]  IDX_FF0_HIGH  = 8'h15;
  localparam logic [7:0]  IDX_FF0_LOW   = 8'h16;
  localparam logic [7:0]  IDX_FF1_HIGH  = 8'h17;
  localparam logic [7:0]  IDX_FF1_LOW   = 8'h18;
  localparam logic [7:0]  IDX_FIRST     = IDX_FB2_HIGH;
  localparam logic [7:0]  IDX_LAST      = IDX_FF1_LOW;

  // reset values
  localparam logic [7:0]  RST_FB2_HIGH  = 8'h84;
  localparam logic [7:0]  RST_FB2_LOW   = 8'hee;
  localparam logic [7:0]  RST_FB4_HIGH  = 8'h7d;
  localparam logic [7:0]  RST_FB4_LOW   = 8'h83;
  localparam logic [7:0]  RST_FB5_HIGH  = 8'h84;
  localparam logic [7:0]  RST_FB5_LOW   = 8'hee;
  localparam logic [7:0]  RST_FF0_HIGH  = 8'h39;
  localparam logic [7:0]  RST_FF0_LOW   = 8'h55;
  localparam logic [7:0]  RST_FF1_HIGH  = 8'hf3;
  localparam logic [7:0]  RST_FF1_LOW   = 8'h2d;

  // reset table, entry n is register IDX_FIRST + n
  localparam logic [NUM_REGS*8-1:0] RST_TABLE = {
    RST_FF1_LOW, RST_FF1_HIGH, RST_FF0_LOW, RST_FF0_HIGH, RST_FB5_LOW,
    RST_FB5_HIGH, RST_FB4_LOW, RST_FB4_HIGH, RST_FB2_LOW, RST_FB2_HIGH};

  typedef enum logic [1:0] {
    LFCB_IDLE   = 2'b00,
    LFCB_ACCESS = 2'b01
  } lfcb_state_type;

endpackage : lfcb_pkg

// *** lfcb_top.sv ***
// Purpose: apb register bank for left playback filter coefficients
// Assumes: mclk 125 MHz, srst synchronous active high
// Notes:   pready answers one cycle into the access phase
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module lfcb_top
  import lfcb_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [lfcb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [lfcb_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [lfcb_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic signed [lfcb_pkg::COEF_W-1:0] feedback_tap_two,
  output logic signed [lfcb_pkg::COEF_W-1:0] feedback_tap_four,
  output logic signed [lfcb_pkg::COEF_W-1:0] feedback_tap_five,
  output logic signed [lfcb_pkg::COEF_W-1:0] feedforward_tap_zero,
  output logic signed [lfcb_pkg::COEF_W-1:0] feedforward_tap_one
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [7:0]          idx;
  logic                hit;
  logic [3:0]          sel_n;
  logic [NUM_REGS-1:0] wr_en;
  logic [7:0]          regs [NUM_REGS];
  lfcb_state_type      state_r;
  lfcb_state_type      state_nxt;

  assign idx   = {2'b00, paddr[7:2]};
  assign hit   = (paddr[1:0] == 2'b00) && (idx >= IDX_FIRST) && (idx <= IDX_LAST);
  assign sel_n = 4'(idx - IDX_FIRST);

  ////////////////////////////////////////////////////////////////////////////
  // apb state: answer in the first access cycle after one wait
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LFCB_IDLE: begin
        if (psel && penable) begin
          state_nxt = LFCB_ACCESS;
        end
      end
      LFCB_ACCESS: begin
        state_nxt = LFCB_IDLE;
      end
      default: begin
        state_nxt = LFCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= LFCB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // access is completed at the edge where pready is seen high
  logic done;
  logic take;
  assign done = psel && penable && pready;
  // first access cycle: the state machine has not answered yet
  assign take = psel && penable && (state_r == LFCB_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // register array with documented reset values
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      assign wr_en[g] = done && pwrite && hit && pstrb[0] && (sel_n == 4'(g));
      lfcb_byte_reg #(
        .RESET_VAL (RST_TABLE[g*8 +: 8])
      ) u_reg (
        .mclk    (mclk),
        .srst    (srst),
        .wr_en   (wr_en[g]),
        .wr_data (pwdata[7:0]),
        .q       (regs[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus answer
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= take;
      pslverr <= take && !hit;
      if (take && !pwrite && hit) begin
        prdata <= {24'h000000, regs[sel_n]};
      end else begin
        prdata <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coefficients to the datapath, high byte first
  always_ff @(posedge mclk) begin
    if (srst) begin
      feedback_tap_two     <= {RST_FB2_HIGH, RST_FB2_LOW};
      feedback_tap_four    <= {RST_FB4_HIGH, RST_FB4_LOW};
      feedback_tap_five    <= {RST_FB5_HIGH, RST_FB5_LOW};
      feedforward_tap_zero <= {RST_FF0_HIGH, RST_FF0_LOW};
      feedforward_tap_one  <= {RST_FF1_HIGH, RST_FF1_LOW};
    end else begin
      feedback_tap_two     <= {regs[0], regs[1]};
      feedback_tap_four    <= {regs[2], regs[3]};
      feedback_tap_five    <= {regs[4], regs[5]};
      feedforward_tap_zero <= {regs[6], regs[7]};
      feedforward_tap_one  <= {regs[8], regs[9]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_coef_pair;
    @(posedge mclk) disable iff (srst)
      1'b1 |=> feedback_tap_four == $signed({$past(regs[2]), $past(regs[3])});
  endproperty
  a_coef_pair: assert property (p_coef_pair) else $error("coef pairing wrong");

  property p_rst_fb2;
    @(posedge mclk) srst |=> regs[0] == 8'h84 && regs[1] == 8'hee;
  endproperty
  a_rst_fb2: assert property (p_rst_fb2) else $error("fb2 reset wrong");
  property p_rst_fb4;
    @(posedge mclk) srst |=> regs[2] == 8'h7d && regs[3] == 8'h83;
  endproperty
  a_rst_fb4: assert property (p_rst_fb4) else $error("fb4 reset wrong");
  property p_rst_fb5;
    @(posedge mclk) srst |=> regs[4] == 8'h84 && regs[5] == 8'hee;
  endproperty
  a_rst_fb5: assert property (p_rst_fb5) else $error("fb5 reset wrong");
  property p_rst_ff0;
    @(posedge mclk) srst |=> regs[6] == 8'h39 && regs[7] == 8'h55;
  endproperty
  a_rst_ff0: assert property (p_rst_ff0) else $error("ff0 reset wrong");
  property p_rst_ff1;
    @(posedge mclk) srst |=> regs[8] == 8'hf3 && regs[9] == 8'h2d;
  endproperty
  a_rst_ff1: assert property (p_rst_ff1) else $error("ff1 reset wrong");
  property p_rst_out;
    @(posedge mclk) srst |=> feedforward_tap_one == 16'hf32d && feedback_tap_two == 16'h84ee;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("output reset wrong");
  property p_write_seen;
    @(posedge mclk) disable iff (srst)
      wr_en[7] |=> ##1 feedforward_tap_zero[7:0] == $past(pwdata[7:0], 2);
  endproperty
  a_write_seen: assert property (p_write_seen) else $error("write not seen");
  property p_ready_bound;
    @(posedge mclk) disable iff (srst) (psel && penable) |-> ##[0:1] pready;
  endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("no ready");

  c_write: cover property (@(posedge mclk) disable iff (srst) done && pwrite && hit);
  c_read:  cover property (@(posedge mclk) disable iff (srst) done && !pwrite && hit);
  c_err:   cover property (@(posedge mclk) disable iff (srst) pready && pslverr);
  c_back:  cover property (@(posedge mclk) disable iff (srst) done ##1 (psel && !penable));
  c_reset: cover property (@(posedge mclk) srst ##1 !srst);

  ////////////////////////////////////////////////////////////////////////////
  // reset values seen on the datapath outputs
  property p_rst_out_fb4;
    @(posedge mclk) srst |=> feedback_tap_four == {RST_FB4_HIGH, RST_FB4_LOW};
  endproperty
  a_rst_out_fb4: assert property (p_rst_out_fb4) else $error("fb4 output reset wrong");

  property p_rst_out_fb5;
    @(posedge mclk) srst |=> feedback_tap_five == {RST_FB5_HIGH, RST_FB5_LOW};
  endproperty
  a_rst_out_fb5: assert property (p_rst_out_fb5) else $error("fb5 output reset wrong");

  property p_rst_out_ff0;
    @(posedge mclk) srst |=> feedforward_tap_zero == {RST_FF0_HIGH, RST_FF0_LOW};
  endproperty
  a_rst_out_ff0: assert property (p_rst_out_ff0) else $error("ff0 output reset wrong");

  ////////////////////////////////////////////////////////////////////////////
  // bus answer shape
  property p_rst_bus;
    @(posedge mclk) srst |=> !pready && !pslverr && prdata == '0;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus answer reset wrong");

  property p_ready_pulse;
    @(posedge mclk) disable iff (srst) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

  property p_err_with_ready;
    @(posedge mclk) disable iff (srst) pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  property p_err_match;
    @(posedge mclk) disable iff (srst) done |-> pslverr == !hit;
  endproperty
  a_err_match: assert property (p_err_match) else $error("pslverr disagrees with decode");

  property p_rdata_quiet;
    @(posedge mclk) disable iff (srst) (!pready || pwrite || pslverr) |-> prdata == '0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("prdata not zero");

  property p_upper_zero;
    @(posedge mclk) disable iff (srst) pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("prdata upper lanes not zero");

  property p_refused_keeps;
    @(posedge mclk) disable iff (srst)
      (done && pwrite && !hit) |=> ##1 $stable(feedback_tap_two) && $stable(feedback_tap_four)
        && $stable(feedback_tap_five) && $stable(feedforward_tap_zero)
        && $stable(feedforward_tap_one);
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("refused write landed");

  ////////////////////////////////////////////////////////////////////////////
  // writes reach the right byte of the right coefficient
  property p_write_fb2_high;
    @(posedge mclk) disable iff (srst)
      wr_en[0] |=> ##1 feedback_tap_two[15:8] == $past(pwdata[7:0], 2);
  endproperty
  a_write_fb2_high: assert property (p_write_fb2_high) else $error("fb2 high write lost");

  property p_write_fb4_low;
    @(posedge mclk) disable iff (srst)
      wr_en[3] |=> ##1 feedback_tap_four[7:0] == $past(pwdata[7:0], 2);
  endproperty
  a_write_fb4_low: assert property (p_write_fb4_low) else $error("fb4 low write lost");

  property p_write_fb5_high;
    @(posedge mclk) disable iff (srst)
      wr_en[4] |=> ##1 feedback_tap_five[15:8] == $past(pwdata[7:0], 2);
  endproperty
  a_write_fb5_high: assert property (p_write_fb5_high) else $error("fb5 high write lost");

  property p_write_ff1_low;
    @(posedge mclk) disable iff (srst)
      wr_en[9] |=> ##1 feedforward_tap_one[7:0] == $past(pwdata[7:0], 2);
  endproperty
  a_write_ff1_low: assert property (p_write_ff1_low) else $error("ff1 low write lost");

  ////////////////////////////////////////////////////////////////////////////
  // reads return the byte that the datapath uses
  property p_read_fb2_high;
    @(posedge mclk) disable iff (srst)
      (done && !pwrite && hit && sel_n == 4'd0) |-> prdata[7:0] == feedback_tap_two[15:8];
  endproperty
  a_read_fb2_high: assert property (p_read_fb2_high) else $error("fb2 high read wrong");

  property p_read_fb4_low;
    @(posedge mclk) disable iff (srst)
      (done && !pwrite && hit && sel_n == 4'd3) |-> prdata[7:0] == feedback_tap_four[7:0];
  endproperty
  a_read_fb4_low: assert property (p_read_fb4_low) else $error("fb4 low read wrong");

  property p_read_fb5_low;
    @(posedge mclk) disable iff (srst)
      (done && !pwrite && hit && sel_n == 4'd5) |-> prdata[7:0] == feedback_tap_five[7:0];
  endproperty
  a_read_fb5_low: assert property (p_read_fb5_low) else $error("fb5 low read wrong");

  property p_read_ff0_high;
    @(posedge mclk) disable iff (srst)
      (done && !pwrite && hit && sel_n == 4'd6) |-> prdata[7:0] == feedforward_tap_zero[15:8];
  endproperty
  a_read_ff0_high: assert property (p_read_ff0_high) else $error("ff0 high read wrong");

  property p_read_ff1_low;
    @(posedge mclk) disable iff (srst)
      (done && !pwrite && hit && sel_n == 4'd9) |-> prdata[7:0] == feedforward_tap_one[7:0];
  endproperty
  a_read_ff1_low: assert property (p_read_ff1_low) else $error("ff1 low read wrong");

endmodule : lfcb_top

// *** test_left_filter_coef_bank.sv ***
// Purpose: self-checking bench for the left filter coefficient bank
// Assumes: apb answer one cycle into access, coefficients lag writes by one cycle
// Notes:   driver queues expected answers, a monitor compares them on pready
`timescale 1ns/100ps
module test_left_filter_coef_bank;
  import lfcb_pkg::*;
  logic                     mclk, srst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]        paddr;
  logic [DATA_W-1:0]        pwdata, prdata;
  logic [3:0]               pstrb;
  logic signed [COEF_W-1:0] feedback_tap_two, feedback_tap_four, feedback_tap_five;
  logic signed [COEF_W-1:0] feedforward_tap_zero, feedforward_tap_one;
  logic [15:0]              cf [NUM_COEFS];
  logic [7:0]               m [NUM_REGS];
  logic [32:0]              q [$];
  int                       mismatches, cmp_count;
  assign cf = '{feedback_tap_two, feedback_tap_four, feedback_tap_five,
                feedforward_tap_zero, feedforward_tap_one};
  lfcb_top uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .feedback_tap_two(feedback_tap_two),
    .feedback_tap_four(feedback_tap_four), .feedback_tap_five(feedback_tap_five),
    .feedforward_tap_zero(feedforward_tap_zero), .feedforward_tap_one(feedforward_tap_one));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [7:0] ad(input int i);
    return {IDX_FIRST[5:0] + 6'(i), 2'b00};
  endfunction : ad
  // request held until pready; released only by idle or the next setup
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, input logic [32:0] exp);
    q.push_back(exp);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
  endtask : apb
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : idle
  task automatic do_reset;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) m[i] = RST_TABLE[i*8 +: 8];
    @(posedge mclk);
  endtask : do_reset
  task automatic read_all;
    for (int i = 0; i < NUM_REGS; i++) apb(ad(i), 1'b0, $urandom, 4'hf, {9'h0, 16'h0, m[i]});
    idle();
    idle();
  endtask : read_all
  task automatic chk_coefs;
    for (int k = 0; k < NUM_COEFS; k++) chk({16'h0, cf[k]}, {16'h0, m[2*k], m[2*k+1]});
  endtask : chk_coefs
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin : mon
    logic [32:0] e;
    if (pready === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        e = q.pop_front();
        chk(prdata, e[31:0]);
        chk({31'h0, pslverr}, {31'h0, e[32]});
      end
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end
  initial begin : main
    logic [31:0] d;
    logic [3:0]  s;
    logic [7:0]  bad [4];
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
    mismatches = 0; cmp_count = 0;
    bad = '{8'h38, 8'h64, 8'h3d, 8'h00};
    void'($urandom(58));
    do_reset();
    read_all();
    chk_coefs();
    $display("test reset values done");
    for (int n = 0; n < 3; n++) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        d = $urandom;
        s = 4'($urandom);
        apb(ad(i), 1'b1, d, s, 33'h0);
        if (s[0]) m[i] = d[7:0];
      end
      read_all();
      chk_coefs();
    end
    $display("test random writes done");
    apb(ad(0), 1'b1, 32'h80, 4'h1, 33'h0);
    apb(ad(1), 1'b1, 32'h00, 4'h1, 33'h0);
    apb(ad(2), 1'b1, 32'h7f, 4'h1, 33'h0);
    apb(ad(3), 1'b1, 32'hff, 4'h1, 33'h0);
    m[0] = 8'h80; m[1] = 8'h00; m[2] = 8'h7f; m[3] = 8'hff;
    read_all();
    chk({31'h0, feedback_tap_two === -32768}, 32'h1);
    chk({31'h0, feedback_tap_four === 32767}, 32'h1);
    $display("test signed extremes done");
    foreach (bad[j]) begin
      apb(bad[j], 1'b1, 32'hff, 4'hf, {1'b1, 32'h0});
      apb(bad[j], 1'b0, 32'h0, 4'hf, {1'b1, 32'h0});
    end
    read_all();
    chk_coefs();
    $display("test refused access done");
    do_reset();
    read_all();
    chk_coefs();
    $display("test second reset done");
    stop_test();
  end
endmodule : test_left_filter_coef_bank
